// ==== verilog/ssadc_pkg.sv ====
package ssadc_pkg;
    // Register byte offsets on the AXI4-Lite bus
    localparam logic [7:0] SSADC_OFF_MODE = 8'h00;
    localparam logic [7:0] SSADC_OFF_TRIM = 8'h04;
    localparam logic [7:0] SSADC_OFF_SYNCW = 8'h08;
    localparam logic [7:0] SSADC_OFF_PERIOD = 8'h0c;
    localparam logic [7:0] SSADC_OFF_RES1 = 8'h10;
    localparam logic [7:0] SSADC_OFF_RES2 = 8'h14;
    localparam logic [7:0] SSADC_OFF_RES3 = 8'h18;
    localparam logic [7:0] SSADC_OFF_RESAUX = 8'h1c;
    localparam logic [7:0] SSADC_OFF_STATUS = 8'h20;
    // Mode control word fields
    localparam int SSADC_MODE_W = 9;
    localparam int SSADC_BIT_RATE = 7;
    localparam int SSADC_BIT_DOUBLE = 8;
    localparam int SSADC_BIT_SEL_HI = 1;
    localparam int SSADC_BIT_SEL_LO = 0;
    // Widths and limits
    localparam int SSADC_CNT_W = 12;
    localparam logic [11:0] SSADC_CNT_MAX = 12'hfff;
    localparam int SSADC_TRIM_W = 3;
    localparam logic [2:0] SSADC_TRIM_RST = 3'h0;
    localparam int SSADC_PER_W = 16;
    localparam logic [15:0] SSADC_PER_RST = 16'hffff;
    localparam logic [15:0] SSADC_SYNCW_RST = 16'h00fa;
    localparam logic [8:0] SSADC_MODE_RST = 9'h000;
    localparam logic [11:0] SSADC_RES_NONE = 12'h000;
    localparam int SSADC_NCH = 4;
    // AXI responses
    localparam logic [1:0] SSADC_RESP_OK = 2'h0;
    localparam logic [1:0] SSADC_RESP_ERR = 2'h2;
    // Conversion sequencer states
    typedef enum logic [2:0] {
        SSADC_IDLE = 3'b001,
        SSADC_RESET = 3'b010,
        SSADC_COUNT = 3'b100
    } ssadc_state_t;
endpackage : ssadc_pkg

// ==== verilog/ssadc_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for the comparator outputs
module ssadc_sync
    import ssadc_pkg::*;
(
    input wire logic clock_i, // Core clock
    input wire logic rst_i, // Async reset
    input wire logic [3:0] d_i, // Raw comparator levels
    output logic [3:0] q_o // Synchronised levels
);
    logic [3:0] meta_reg;
    // Only the second stage is read downstream
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            meta_reg <= 4'h0;
            q_o <= 4'h0;
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule : ssadc_sync
`default_nettype wire

// ==== verilog/ssadc_capture.sv ====
`timescale 1ns/1ps
`default_nettype none
// One channel's first-trip capture
module ssadc_capture
    import ssadc_pkg::*;
(
    input wire logic clock_i, // Core clock
    input wire logic rst_i, // Async reset
    input wire logic start_i, // New conversion begins
    input wire logic counting_i, // Counter window open
    input wire logic trip_i, // Synchronised comparator
    input wire logic [11:0] count_i, // Shared counter
    input wire logic done_i, // Window closed
    output logic [11:0] result_o, // Published result
    output logic tripped_o // Tripped this conversion, held until start
);
    logic [11:0] hold_reg;
    // Latch first trip only, publish at window end
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            hold_reg <= SSADC_RES_NONE;
            tripped_o <= 1'b0;
            result_o <= SSADC_RES_NONE;
        end else begin
            if (start_i) begin
                tripped_o <= 1'b0;
                hold_reg <= SSADC_RES_NONE;
            end else if (counting_i && trip_i && !tripped_o) begin
                hold_reg <= count_i;
                tripped_o <= 1'b1;
            end
            if (done_i) begin
                result_o <= hold_reg;
            end
        end
    end
endmodule : ssadc_capture
`default_nettype wire

// ==== verilog/ssadc_timer.sv ====
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Aux select bits pick input or reference
// - Four channels share one counter
// - Twelve-bit count from start is result
// - First trip on each channel captures count into own register
// - Mode bit 7 picks full or half rate
// - Sync pulse discharges ramp, restarts counter
// - Sync width comes from a register
// - Count limited to 4095 and remaining time
// - Period halves in double update mode
// - Three-bit ramp trim, resets to zero
// - No trip by window end gives zero
module ssadc_timer
    import ssadc_pkg::*;
(
    input wire logic clock_i, // Core clock 125 MHz
    input wire logic rst_i, // Async reset, high
    input wire logic cycle_sync_i, // Start of PWM cycle
    input wire logic [3:0] comp_i, // Comparators ch1..3, aux
    input wire logic [31:0] s_axi_awaddr, // AXI write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [31:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    output logic ramp_reset_o, // Ramp discharge, high
    output logic [1:0] aux_select_o, // Aux mux code
    output logic [2:0] ramp_current_trim_o // Current source trim
);
    ////////////////////////////////////////////////////////////////////////
    logic [8:0] mode_control_word_reg;
    logic [2:0] ramp_current_trim_reg;
    logic [15:0] sync_width_setting_reg;
    logic [15:0] period_reg;
    ssadc_state_t state_reg;
    logic [15:0] phase_reg;
    logic [11:0] count_reg;
    logic [11:0] limit_reg;
    logic half_reg;
    logic start;
    logic done;
    logic counting;
    logic [3:0] comp_sync;
    logic [3:0] tripped;
    logic [11:0] res [SSADC_NCH];
    logic [15:0] conv_period;
    logic [15:0] avail;
    logic [15:0] limit_next;
    logic aw_hold_reg;
    logic w_hold_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;

    // Merge byte lanes into a stored word
    function automatic logic [31:0] ssadc_merge(input logic [31:0] old, input logic [31:0] nw,
                                                input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : ssadc_merge

    ////////////////////////////////////////////////////////////////////////
    // Comparator synchroniser
    ssadc_sync u_ssadc_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .d_i(comp_i),
        .q_o(comp_sync)
    );

    // One capture per channel on the shared counter
    for (genvar c = 0; c < SSADC_NCH; c++) begin : g_ch
        ssadc_capture u_ssadc_capture (
            .clock_i(clock_i),
            .rst_i(rst_i),
            .start_i(start),
            .counting_i(counting),
            .trip_i(comp_sync[c]),
            .count_i(count_reg),
            .done_i(done),
            .result_o(res[c]),
            .tripped_o(tripped[c])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Conversion period and count limit
    always_comb begin
        conv_period = mode_control_word_reg[SSADC_BIT_DOUBLE] ? {1'b0, period_reg[15:1]} : period_reg;
        avail = (conv_period > sync_width_setting_reg) ? 16'(conv_period - sync_width_setting_reg) : 16'h0000;
        if (!mode_control_word_reg[SSADC_BIT_RATE]) begin
            avail = {1'b0, avail[15:1]};
        end
        limit_next = (avail > 16'(SSADC_CNT_MAX)) ? 16'(SSADC_CNT_MAX) : avail;
    end

    assign start = cycle_sync_i;
    assign counting = (state_reg == SSADC_COUNT);
    assign done = start || (counting && (phase_reg == conv_period - 16'h0001));

    // Sequencer: sync pulse, then counting window
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= SSADC_IDLE;
            phase_reg <= 16'h0000;
            ramp_reset_o <= 1'b0;
            limit_reg <= 12'h000;
        end else begin
            phase_reg <= 16'(phase_reg + 16'h0001);
            case (state_reg)
                SSADC_IDLE: begin
                    ramp_reset_o <= 1'b0;
                end
                SSADC_RESET: begin
                    if (phase_reg + 16'h0001 >= sync_width_setting_reg) begin
                        state_reg <= SSADC_COUNT;
                        ramp_reset_o <= 1'b0;
                    end
                end
                SSADC_COUNT: begin
                    if (done) begin
                        state_reg <= SSADC_IDLE;
                    end
                end
                default: state_reg <= SSADC_IDLE;
            endcase
            if (start) begin
                state_reg <= SSADC_RESET;
                phase_reg <= 16'h0000;
                ramp_reset_o <= 1'b1;
                limit_reg <= limit_next[11:0];
            end
        end
    end

    // Shared counter, full or half rate, saturating at limit
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            count_reg <= 12'h000;
            half_reg <= 1'b0;
        end else if (start) begin
            count_reg <= 12'h000;
            half_reg <= 1'b0;
        end else if (counting) begin
            half_reg <= ~half_reg;
            if ((mode_control_word_reg[SSADC_BIT_RATE] || half_reg) && count_reg < limit_reg) begin
                count_reg <= 12'(count_reg + 12'h001);
            end
        end
    end

    // Auxiliary mux select and trim outputs
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            aux_select_o <= 2'h0;
            ramp_current_trim_o <= SSADC_TRIM_RST;
        end else begin
            aux_select_o <= {mode_control_word_reg[SSADC_BIT_SEL_HI],
                             mode_control_word_reg[SSADC_BIT_SEL_LO]};
            ramp_current_trim_o <= ramp_current_trim_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI write channel capture, either order
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= SSADC_RESP_OK;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                s_axi_awready <= 1'b0; // Closed until the response is taken
                awaddr_reg <= s_axi_awaddr[7:0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                s_axi_wready <= 1'b0;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (aw_hold_reg && w_hold_reg && !s_axi_bvalid) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_reg == SSADC_OFF_MODE || awaddr_reg == SSADC_OFF_TRIM ||
                                awaddr_reg == SSADC_OFF_SYNCW || awaddr_reg == SSADC_OFF_PERIOD)
                               ? SSADC_RESP_OK : SSADC_RESP_ERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1; // Reopen both channels together
                s_axi_wready <= 1'b1;
            end
        end
    end


    // Register writes
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            mode_control_word_reg <= SSADC_MODE_RST;
            ramp_current_trim_reg <= SSADC_TRIM_RST;
            sync_width_setting_reg <= SSADC_SYNCW_RST;
            period_reg <= SSADC_PER_RST;
        end else if (aw_hold_reg && w_hold_reg && !s_axi_bvalid) begin
            case (awaddr_reg)
                SSADC_OFF_MODE: mode_control_word_reg <=
                    9'(ssadc_merge(32'(mode_control_word_reg), wdata_reg, wstrb_reg));
                SSADC_OFF_TRIM: ramp_current_trim_reg <=
                    3'(ssadc_merge(32'(ramp_current_trim_reg), wdata_reg, wstrb_reg));
                SSADC_OFF_SYNCW: sync_width_setting_reg <=
                    16'(ssadc_merge(32'(sync_width_setting_reg), wdata_reg, wstrb_reg));
                SSADC_OFF_PERIOD: period_reg <=
                    16'(ssadc_merge(32'(period_reg), wdata_reg, wstrb_reg));
                default: ;
            endcase
        end
    end

    // Read channel, one cycle answer
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= SSADC_RESP_OK;
            s_axi_arready <= 1'b1;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_arready <= 1'b0; // One read in flight
            s_axi_rresp <= SSADC_RESP_OK;
            case (s_axi_araddr[7:0])
                SSADC_OFF_MODE: s_axi_rdata <= 32'(mode_control_word_reg);
                SSADC_OFF_TRIM: s_axi_rdata <= 32'(ramp_current_trim_reg);
                SSADC_OFF_SYNCW: s_axi_rdata <= 32'(sync_width_setting_reg);
                SSADC_OFF_PERIOD: s_axi_rdata <= 32'(period_reg);
                SSADC_OFF_RES1: s_axi_rdata <= 32'(res[0]);
                SSADC_OFF_RES2: s_axi_rdata <= 32'(res[1]);
                SSADC_OFF_RES3: s_axi_rdata <= 32'(res[2]);
                SSADC_OFF_RESAUX: s_axi_rdata <= 32'(res[3]);
                SSADC_OFF_STATUS: s_axi_rdata <= {26'h0, counting, ramp_reset_o, tripped};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= SSADC_RESP_ERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end


    ////////////////////////////////////////////////////////////////////////
    a_sync_discharge: assert property (@(posedge clock_i) disable iff (rst_i)
        start |=> ramp_reset_o && count_reg == 12'h000) else $error("sync did not discharge");
    a_count_limit: assert property (@(posedge clock_i) disable iff (rst_i)
        count_reg <= limit_reg || $past(start)) else $error("count above limit");
    a_half_rate: assert property (@(posedge clock_i) disable iff (rst_i)
        counting && !mode_control_word_reg[SSADC_BIT_RATE] && !start && $past(counting)
        && $changed(count_reg) |=> $stable(count_reg) || start) else $error("half rate too fast");
    a_full_rate: assert property (@(posedge clock_i) disable iff (rst_i)
        counting && mode_control_word_reg[SSADC_BIT_RATE] && count_reg < limit_reg && !start
        |=> count_reg == $past(count_reg) + 12'h001 || start || !counting) else $error("full rate stalled");
    a_aux_route: assert property (@(posedge clock_i) disable iff (rst_i)
        ##1 aux_select_o == $past(mode_control_word_reg[1:0])) else $error("aux select wrong");
    a_trim_drive: assert property (@(posedge clock_i) disable iff (rst_i)
        ##1 ramp_current_trim_o == $past(ramp_current_trim_reg)) else $error("trim not driven");
    a_width_hold: assert property (@(posedge clock_i) disable iff (rst_i)
        state_reg == SSADC_RESET |-> ramp_reset_o && !counting) else $error("ramp released early");
    a_no_count_idle: assert property (@(posedge clock_i) disable iff (rst_i)
        !counting && !start |=> $stable(count_reg)) else $error("counter moved outside window");
    a_first_trip: assert property (@(posedge clock_i) disable iff (rst_i)
        tripped[0] && !start |=> tripped[0]) else $error("trip flag lost");
    a_untripped_zero: assert property (@(posedge clock_i) disable iff (rst_i)
        done && !tripped[SSADC_NCH - 1] |=> res[SSADC_NCH - 1] == SSADC_RES_NONE) else $error("untripped not zero");
endmodule : ssadc_timer
`default_nettype wire

// ==== dv/ssadc_analog_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Far side: sync source, ramp capacitor and four comparators
module ssadc_analog_model
    import ssadc_pkg::*;
(
    input wire logic clock_i, // Core clock
    input wire logic rst_i, // Async reset
    input wire logic fire_i, // Request one sync pulse
    input wire logic glitch_i, // Bounce channel 1 after its trip
    input wire logic [63:0] trip_at_i, // Ramp cycles to trip, ch1..aux
    input wire logic ramp_reset_i, // Discharge from the device
    output logic cycle_sync_o, // One-cycle sync pulse
    output logic [3:0] comp_o // Comparator levels, high when tripped
);
    logic [15:0] ramp_reg;
    ////////////////////////////////////////////////////////////
    // One sync pulse per request; the bench spaces them a period apart
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cycle_sync_o <= 1'b0;
        end else begin
            cycle_sync_o <= fire_i;
        end
    end
    // Ramp sits at zero while discharged, then rises one step a cycle
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ramp_reg <= 16'h0000;
        end else if (ramp_reset_i) begin
            ramp_reg <= 16'h0000;
        end else if (ramp_reg != 16'hffff) begin
            ramp_reg <= ramp_reg + 16'h0001;
        end
    end
    // Trip once the ramp passes the input; channel 1 may bounce after
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            comp_o <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                comp_o[i] <= (ramp_reg >= trip_at_i[16*i +: 16]);
            end
            if (glitch_i && ramp_reg >= trip_at_i[15:0] + 16'h0003 && ramp_reg < trip_at_i[15:0] + 16'h0014) begin
                comp_o[0] <= 1'b0;
            end
        end
    end
endmodule : ssadc_analog_model
`default_nettype wire

// ==== dv/test_ssadc_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the single-slope timer
module test_ssadc_timer;
    import ssadc_pkg::*;
    typedef struct packed {logic [31:0] lo; logic [31:0] hi; logic [1:0] rs;} ssadc_exp_t;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic sync, fire = 1'b0, glitch = 1'b0;
    logic [3:0] comp;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, g0, g1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, ramp_reset;
    logic [1:0] bresp, rresp, aux_sel, be;
    logic [2:0] trim;
    logic [31:0] seed = 32'h65fa;
    logic [63:0] trip_at = 64'h0;
    logic [15:0] d0, d1, m;
    ssadc_exp_t r_q[$], e;
    logic [1:0] b_q[$];
    logic [31:0] got_q[$];
    int err_total = 0, checks_done = 0, cycles = 0, rr_len = 0;
    ////////////////////////////////////////////////////////////
    ssadc_timer u_ssadc_timer (.clock_i(clock_i), .rst_i(rst_i), .cycle_sync_i(sync), .comp_i(comp),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .ramp_reset_o(ramp_reset), .aux_select_o(aux_sel), .ramp_current_trim_o(trim));
    ssadc_analog_model u_ssadc_analog_model (.clock_i(clock_i), .rst_i(rst_i), .fire_i(fire),
        .glitch_i(glitch), .trip_at_i(trip_at), .ramp_reset_i(ramp_reset), .cycle_sync_o(sync), .comp_o(comp));
    ////////////////////////////////////////////////////////////
    // Clock, 8 ns period
    initial begin
        forever #4 clock_i = ~clock_i;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : chk
    task automatic end_sim();
        $display("errors %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim
    // Write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        b_q.push_back(rs);
        awaddr <= {24'h0, a};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clock_i);
            if (awvalid && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        @(posedge clock_i);
        while (!bvalid) @(posedge clock_i);
        bready <= 1'b0;
    endtask : wr
    // Read: expected window noted first, the monitor compares
    task automatic rd(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi, input logic [1:0] rs);
        r_q.push_back('{lo, hi, rs});
        araddr <= {24'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(posedge clock_i);
        while (!arready) @(posedge clock_i);
        arvalid <= 1'b0;
        @(posedge clock_i);
        while (!rvalid) @(posedge clock_i);
        rready <= 1'b0;
    endtask : rd
    // One conversion window, then wait past its end
    task automatic conv(input int per);
        fire <= 1'b1;
        @(posedge clock_i);
        fire <= 1'b0;
        repeat (per + 100) @(posedge clock_i);
    endtask : conv
    // Spacing of the two first channels from the last four reads
    task automatic rel(input logic [31:0] diff);
        @(posedge clock_i);
        g0 = got_q[got_q.size() - 4];
        g1 = got_q[got_q.size() - 3];
        chk(g1 - g0 === diff, "channel spacing");
    endtask : rel
    ////////////////////////////////////////////////////////////
    // Response monitors
    always @(posedge clock_i) begin
        if (rvalid && rready) begin
            got_q.push_back(rdata);
            e = r_q.pop_front();
            chk(rdata >= e.lo && rdata <= e.hi && rresp === e.rs, "read data or response");
        end
        if (bvalid && bready) begin
            be = b_q.pop_front();
            chk(bresp === be, "write response");
        end
        if (ramp_reset === 1'b1) begin
            rr_len++;
        end else if (rr_len != 0) begin
            chk(rr_len == 20, "ramp reset width");
            rr_len = 0;
        end
    end
    // Watchdog
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            err_total++;
            $display("[FAIL] %0t timeout", $time);
            end_sim();
        end
    end
    // Main sequence
    initial begin
        repeat (20) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        chk(trim === SSADC_TRIM_RST, "trim after reset");
        rd(SSADC_OFF_MODE, 32'h0, 32'h0, SSADC_RESP_OK);
        rd(SSADC_OFF_SYNCW, 32'hfa, 32'hfa, SSADC_RESP_OK);
        rd(SSADC_OFF_PERIOD, 32'hffff, 32'hffff, SSADC_RESP_OK);
        rd(SSADC_OFF_RES1, 32'h0, 32'h0, SSADC_RESP_OK);
        rd(8'h24, 32'h0, 32'h0, SSADC_RESP_ERR);
        wr(8'h24, 32'h5a5a5a5a, SSADC_RESP_ERR);
        for (int i = 0; i < 4; i++) begin
            wr(SSADC_OFF_MODE, 32'h80 | i, SSADC_RESP_OK);
            repeat (2) @(posedge clock_i);
            chk(aux_sel === i[1:0], "aux select code");
        end
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            wr(SSADC_OFF_TRIM, {seed[31:3], i[2:0]}, SSADC_RESP_OK);
            rd(SSADC_OFF_TRIM, i, i, SSADC_RESP_OK);
            chk(trim === i[2:0], "trim output");
        end
        // Full rate: bounce on ch1, ch3 past the 4095 cap, aux never trips
        wr(SSADC_OFF_SYNCW, 32'd20, SSADC_RESP_OK);
        wr(SSADC_OFF_PERIOD, 32'd6000, SSADC_RESP_OK);
        seed = lfsr(seed);
        d0 = 16'd200 + {seed[5:0], 1'b0};
        d1 = d0 + 16'd600 + {seed[11:6], 1'b0};
        trip_at <= {16'd6500, 16'd4500, d1, d0};
        glitch <= 1'b1;
        conv(6000);
        rd(SSADC_OFF_RES1, d0 - 6, d0 + 6, SSADC_RESP_OK);
        rd(SSADC_OFF_RES2, d1 - 6, d1 + 6, SSADC_RESP_OK);
        rd(SSADC_OFF_RES3, 32'hfff, 32'hfff, SSADC_RESP_OK);
        rd(SSADC_OFF_RESAUX, 32'h0, 32'h0, SSADC_RESP_OK);
        rel(d1 - d0);
        rd(SSADC_OFF_STATUS, 32'h7, 32'h7, SSADC_RESP_OK);
        // Half rate, aux on input 2
        wr(SSADC_OFF_MODE, 32'h002, SSADC_RESP_OK);
        wr(SSADC_OFF_PERIOD, 32'd3000, SSADC_RESP_OK);
        seed = lfsr(seed);
        d0 = 16'd100 + {seed[4:0], 1'b0};
        m = 16'd200 + seed[12:5];
        d1 = d0 + 2 * m;
        trip_at <= {16'd1500, 16'd6000, d1, d0};
        glitch <= 1'b0;
        conv(3000);
        rd(SSADC_OFF_RES1, d0 / 2 - 4, d0 / 2 + 4, SSADC_RESP_OK);
        rd(SSADC_OFF_RES2, d1 / 2 - 4, d1 / 2 + 4, SSADC_RESP_OK);
        rd(SSADC_OFF_RES3, 32'h0, 32'h0, SSADC_RESP_OK);
        rd(SSADC_OFF_RESAUX, 32'd746, 32'd754, SSADC_RESP_OK);
        rel(m);
        // Double update: window is half the programmed period
        wr(SSADC_OFF_MODE, 32'h180, SSADC_RESP_OK);
        wr(SSADC_OFF_PERIOD, 32'd12000, SSADC_RESP_OK);
        trip_at <= {16'd300, 16'd6500, 16'd7000, 16'd1000};
        conv(6000);
        rd(SSADC_OFF_RES1, 32'd994, 32'd1006, SSADC_RESP_OK);
        rd(SSADC_OFF_RES2, 32'h0, 32'h0, SSADC_RESP_OK);
        rd(SSADC_OFF_RES3, 32'h0, 32'h0, SSADC_RESP_OK);
        rd(SSADC_OFF_RESAUX, 32'd294, 32'd306, SSADC_RESP_OK);
        repeat (4) @(posedge clock_i);
        chk(r_q.size() == 0 && b_q.size() == 0, "responses outstanding");
        end_sim();
    end
endmodule : test_ssadc_timer
`default_nettype wire
